// file: logic/bcr_pkg.sv
package bcr_pkg;
  // Register offsets on the functional page
  localparam logic [7:0] ADDR_BUCK_ONE_CONFIG       = 8'h24;
  localparam logic [7:0] ADDR_BUCK_ONE_CONFIG_ALIAS = 8'h32;
  localparam logic [7:0] ADDR_BUCK_TWO_VOLTAGE      = 8'h35;
  // Field positions, first buck configuration
  localparam int STEP_RATE_BIT = 6;
  localparam int PHASE_HI      = 5;
  localparam int PHASE_LO      = 4;
  localparam int FREQ_HI       = 3;
  localparam int FREQ_LO       = 2;
  localparam int ILIM_BIT      = 0;
  localparam logic [7:0] CONFIG_IMPL_MASK  = 8'h7d;
  // Phase bits are not OTP fields: they always come up zero
  localparam logic [7:0] CONFIG_OTP_MASK   = 8'h4d;
  // Field positions, second buck voltage
  localparam int VOLT_HI       = 4;
  localparam int VOLT_LO       = 0;
  localparam int RANGE_BIT     = 5;
  localparam logic [7:0] VOLTAGE_IMPL_MASK = 8'h3f;
  localparam logic [7:0] ZERO_BYTE         = 8'h00;
  // Dynamic voltage stepping
  localparam int CLK_MHZ        = 100;
  localparam int STEP_FAST_NS   = 2000;
  localparam int STEP_SLOW_NS   = 4000;
  localparam int STEP_FAST_CYC  = STEP_FAST_NS * CLK_MHZ / 1000;
  localparam int STEP_SLOW_CYC  = STEP_SLOW_NS * CLK_MHZ / 1000;
  localparam int STEP_CNT_W     = 10;
  localparam int STEP_MV        = 25;
endpackage : bcr_pkg

// file: logic/bcr_step_if.sv
`timescale 1ns/1ps
interface bcr_step_if;
  logic       slow;
  logic       tick;
  modport ctrl  (output slow, input tick);
  modport timer (input slow, output tick);
endinterface : bcr_step_if

// file: logic/bcr_step_timer.sv
`timescale 1ns/1ps
module bcr_step_timer (
  // Clock and reset
  input  wire logic  mclk_in,
  input  wire logic  rst_b_in,
  // Pacing
  bcr_step_if.timer  step
);
  typedef struct packed {
    logic [bcr_pkg::STEP_CNT_W-1:0] cnt;
    logic                           tick;
  } bcr_tmr_t;

  localparam int CNT_W = bcr_pkg::STEP_CNT_W;

  bcr_tmr_t         st_q;
  bcr_tmr_t         st_d;
  logic [CNT_W-1:0] last;

  // Slow pace has the longest count, so it sets the counter width
  if (bcr_pkg::STEP_SLOW_CYC >= (1 << CNT_W)) begin : g_bad_cnt_w
    $error("Step counter too narrow for the slow pace");
  end

  always_comb begin
    // One 25 mV step per tick: 2.0 us fast, 4.0 us slow
    last = step.slow ? CNT_W'(bcr_pkg::STEP_SLOW_CYC - 1)
                     : CNT_W'(bcr_pkg::STEP_FAST_CYC - 1);
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt >= last) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign step.tick = st_q.tick;
endmodule : bcr_step_timer

// file: logic/bcr_regs.sv
`timescale 1ns/1ps
module bcr_regs #(
  // Register and field widths
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int CODE_W = 5,
  parameter int SEL_W  = 2
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // One-time-programmable defaults, stable at reset release
  input  wire logic [DATA_W-1:0] otp_buck_one_config_in,
  input  wire logic [DATA_W-1:0] otp_buck_two_voltage_in,
  // Register access port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // First buck controls
  input  wire logic [CODE_W-1:0] buck_one_target_in,
  output logic      [CODE_W-1:0] buck_one_code_out,
  output logic                   buck_one_step_out,
  output logic      [SEL_W-1:0]  buck_one_phase_sel_out,
  output logic      [SEL_W-1:0]  buck_one_freq_sel_out,
  output logic                   buck_one_current_limit_out,
  // Second buck controls
  output logic      [CODE_W-1:0] buck_two_voltage_out,
  output logic                   buck_two_range_high_out
);

  // Field positions are fixed by the register map, so only these widths fit it
  if (DATA_W != 8) begin : g_bad_data_w
    $error("Register data must be 8 bits wide");
  end
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("Register offsets need at least 8 address bits");
  end
  if (CODE_W != bcr_pkg::VOLT_HI - bcr_pkg::VOLT_LO + 1) begin : g_bad_code_w
    $error("Voltage code width must match its register field");
  end
  if (SEL_W != bcr_pkg::PHASE_HI - bcr_pkg::PHASE_LO + 1) begin : g_bad_phase_w
    $error("Phase selector width must match its register field");
  end
  if (SEL_W != bcr_pkg::FREQ_HI - bcr_pkg::FREQ_LO + 1) begin : g_bad_freq_w
    $error("Frequency selector width must match its register field");
  end

  // Masks and offsets must agree with the layout the logic assumes
  if ((bcr_pkg::CONFIG_OTP_MASK & ~bcr_pkg::CONFIG_IMPL_MASK) != bcr_pkg::ZERO_BYTE) begin : g_bad_otp_mask
    $error("OTP defaults may only reach implemented config bits");
  end
  if (!bcr_pkg::CONFIG_IMPL_MASK[bcr_pkg::STEP_RATE_BIT] || !bcr_pkg::CONFIG_IMPL_MASK[bcr_pkg::ILIM_BIT]) begin : g_bad_cfg_mask
    $error("Config mask must keep the step-rate and current-limit bits");
  end
  if (!bcr_pkg::VOLTAGE_IMPL_MASK[bcr_pkg::RANGE_BIT]) begin : g_bad_volt_mask
    $error("Voltage mask must keep the range bit");
  end
  if (bcr_pkg::ADDR_BUCK_TWO_VOLTAGE == bcr_pkg::ADDR_BUCK_ONE_CONFIG ||
      bcr_pkg::ADDR_BUCK_TWO_VOLTAGE == bcr_pkg::ADDR_BUCK_ONE_CONFIG_ALIAS) begin : g_bad_offsets
    $error("Voltage register may not share a config offset");
  end

  typedef struct packed {
    logic              loaded;
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] volt;
    logic [DATA_W-1:0] rdata;
    logic [CODE_W-1:0] code;
    logic              step;
  } bcr_state_t;

  typedef enum {
    RAMP_HOLD,
    RAMP_UP,
    RAMP_DOWN
  } bcr_ramp_t;

  bcr_state_t        st_q;
  bcr_state_t        st_d;
  bcr_step_if        step_bus ();

  // Address decode
  logic              hit_cfg;
  logic              hit_cfg_alias;
  logic              hit_volt;
  // Masked candidates for the stored bytes
  logic [DATA_W-1:0] otp_cfg;
  logic [DATA_W-1:0] otp_volt;
  logic [DATA_W-1:0] wr_cfg;
  logic [DATA_W-1:0] wr_volt;
  // Next values of the stored fields
  logic [DATA_W-1:0] cfg_next;
  logic [DATA_W-1:0] volt_next;
  logic [DATA_W-1:0] rdata_next;
  // Ramp of the first buck code
  bcr_ramp_t         ramp;
  logic              step_due;
  logic [CODE_W-1:0] code_next;

  bcr_step_timer u_step_timer (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .step     (step_bus.timer)
  );

  assign step_bus.slow = st_q.cfg[bcr_pkg::STEP_RATE_BIT];

  // Shared by the write and read paths
  always_comb begin
    hit_cfg       = (reg_addr_in == ADDR_W'(bcr_pkg::ADDR_BUCK_ONE_CONFIG));
    hit_cfg_alias = (reg_addr_in == ADDR_W'(bcr_pkg::ADDR_BUCK_ONE_CONFIG_ALIAS));
    hit_volt      = (reg_addr_in == ADDR_W'(bcr_pkg::ADDR_BUCK_TWO_VOLTAGE));
  end

  always_comb begin
    otp_cfg  = otp_buck_one_config_in & bcr_pkg::CONFIG_OTP_MASK;
    otp_volt = otp_buck_two_voltage_in & bcr_pkg::VOLTAGE_IMPL_MASK;
    wr_cfg   = reg_wdata_in & bcr_pkg::CONFIG_IMPL_MASK;
    wr_volt  = reg_wdata_in & bcr_pkg::VOLTAGE_IMPL_MASK;
  end

  // No operating-state gating: a write lands whenever the bank is loaded
  always_comb begin
    cfg_next  = st_q.cfg;
    volt_next = st_q.volt;
    if (!st_q.loaded) begin
      // OTP is caught on the first clock after release, never by the async reset
      cfg_next  = otp_cfg;
      volt_next = otp_volt;
    end else if (reg_wr_in) begin
      if (hit_cfg || hit_cfg_alias) begin
        cfg_next = wr_cfg;
      end
      if (hit_volt) begin
        volt_next = wr_volt;
      end
    end
  end

  // One code per tick toward the target; the pace comes from the timer
  always_comb begin
    if (!st_q.loaded || st_q.code == buck_one_target_in) begin
      ramp = RAMP_HOLD;
    end else if (st_q.code < buck_one_target_in) begin
      ramp = RAMP_UP;
    end else begin
      ramp = RAMP_DOWN;
    end
    step_due  = step_bus.tick && (ramp != RAMP_HOLD);
    code_next = st_q.code;
    if (!st_q.loaded) begin
      // Start at the target so nothing ramps out of reset
      code_next = buck_one_target_in;
    end else if (step_due) begin
      case (ramp)
        RAMP_UP: begin
          code_next = st_q.code + 1'b1;
        end
        RAMP_DOWN: begin
          code_next = st_q.code - 1'b1;
        end
        default: begin
          code_next = st_q.code;
        end
      endcase
    end
  end

  // Read data is registered: the byte for an address shows one cycle later
  always_comb begin
    case ({hit_volt, hit_cfg_alias, hit_cfg})
      3'h1: begin
        rdata_next = st_q.cfg;
      end
      3'h2: begin
        rdata_next = st_q.cfg;
      end
      3'h4: begin
        rdata_next = st_q.volt;
      end
      default: begin
        rdata_next = bcr_pkg::ZERO_BYTE;
      end
    endcase
  end

  always_comb begin
    st_d        = st_q;
    st_d.loaded = 1'b1;
    st_d.cfg    = cfg_next;
    st_d.volt   = volt_next;
    st_d.rdata  = rdata_next;
    st_d.code   = code_next;
    st_d.step   = step_due;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out              = st_q.rdata;
  assign buck_one_code_out          = st_q.code;
  assign buck_one_step_out          = st_q.step;
  assign buck_one_phase_sel_out     = st_q.cfg[bcr_pkg::PHASE_HI:bcr_pkg::PHASE_LO];
  assign buck_one_freq_sel_out      = st_q.cfg[bcr_pkg::FREQ_HI:bcr_pkg::FREQ_LO];
  assign buck_one_current_limit_out = st_q.cfg[bcr_pkg::ILIM_BIT];
  assign buck_two_voltage_out       = st_q.volt[bcr_pkg::VOLT_HI:bcr_pkg::VOLT_LO];
  assign buck_two_range_high_out    = st_q.volt[bcr_pkg::RANGE_BIT];
endmodule : bcr_regs

// file: test/bcr_regs_properties.sv
`timescale 1ns/1ps
module bcr_regs_properties (
  input wire logic       mclk_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [4:0] buck_one_code_out,
  input wire logic       buck_one_step_out,
  input wire logic [1:0] buck_one_phase_sel_out,
  input wire logic [1:0] buck_one_freq_sel_out,
  input wire logic       buck_one_current_limit_out,
  input wire logic [4:0] buck_two_voltage_out,
  input wire logic       buck_two_range_high_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_cfg;
    reg_wr_in && (reg_addr_in == 8'h24 || reg_addr_in == 8'h32);
  endsequence
  sequence s_volt;
    reg_wr_in && reg_addr_in == 8'h35;
  endsequence
  chk_phase_wr: assert property (s_cfg |=> buck_one_phase_sel_out == $past(reg_wdata_in[5:4]))
    else $error("phase select not written");
  chk_freq_wr: assert property (s_cfg |=> buck_one_freq_sel_out == $past(reg_wdata_in[3:2]))
    else $error("frequency select not written");
  chk_ilim_wr: assert property (s_cfg |=> buck_one_current_limit_out == $past(reg_wdata_in[0]))
    else $error("current limit not written");
  chk_volt_wr: assert property (s_volt |=> buck_two_voltage_out == $past(reg_wdata_in[4:0]))
    else $error("voltage code not written");
  chk_range_wr: assert property (s_volt |=> buck_two_range_high_out == $past(reg_wdata_in[5]))
    else $error("range bit not written");
  chk_top_zero: assert property (reg_rdata_out[7] == 1'b0)
    else $error("bit 7 read nonzero");
  chk_volt_read: assert property (reg_addr_in == 8'h35 |=> reg_rdata_out ==
    {2'h0, $past(buck_two_range_high_out), $past(buck_two_voltage_out)}) else $error("voltage read wrong");
  chk_cfg_read: assert property (reg_addr_in == 8'h24 || reg_addr_in == 8'h32 |=> reg_rdata_out[5:0] ==
    {$past(buck_one_phase_sel_out), $past(buck_one_freq_sel_out), 1'b0, $past(buck_one_current_limit_out)})
    else $error("config read wrong");
  chk_step_one: assert property (buck_one_step_out |-> buck_one_code_out - $past(buck_one_code_out) == 5'h01 ||
    $past(buck_one_code_out) - buck_one_code_out == 5'h01) else $error("step not one code");
  chk_step_gap: assert property (buck_one_step_out |=> !buck_one_step_out [*8])
    else $error("steps too close");
endmodule : bcr_regs_properties
bind bcr_regs bcr_regs_properties u_chk (
  .mclk_in                    (mclk_in),
  .rst_b_in                   (rst_b_in),
  .reg_addr_in                (reg_addr_in),
  .reg_wr_in                  (reg_wr_in),
  .reg_wdata_in               (reg_wdata_in),
  .reg_rdata_out              (reg_rdata_out),
  .buck_one_code_out          (buck_one_code_out),
  .buck_one_step_out          (buck_one_step_out),
  .buck_one_phase_sel_out     (buck_one_phase_sel_out),
  .buck_one_freq_sel_out      (buck_one_freq_sel_out),
  .buck_one_current_limit_out (buck_one_current_limit_out),
  .buck_two_voltage_out       (buck_two_voltage_out),
  .buck_two_range_high_out    (buck_two_range_high_out)
);

// file: test/tb_bcr_regs.sv
`timescale 1ns/1ps
module tb_bcr_regs;
  logic       clk = 0, rst_b = 0, wr = 0, stp, ilim, hi;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd_q;
  logic [4:0] tgt = 5'h00, code, volt;
  logic [1:0] ph, fq;
  int         bad_count = 0, check_count = 0, n;
  initial forever #5 clk = ~clk;
  // OTP all ones: phase bits must still come up zero, unused bits must read zero
  bcr_regs DUT (.mclk_in(clk), .rst_b_in(rst_b), .otp_buck_one_config_in(8'hff), .otp_buck_two_voltage_in(8'hff),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd_q), .buck_one_target_in(tgt),
    .buck_one_code_out(code), .buck_one_step_out(stp), .buck_one_phase_sel_out(ph), .buck_one_freq_sel_out(fq),
    .buck_one_current_limit_out(ilim), .buck_two_voltage_out(volt), .buck_two_range_high_out(hi));
  task chk(string nm, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge clk); addr = a; wd = d; wr = 1;
    @(negedge clk); wr = 0;
  endtask : wr_reg
  task rd_reg(logic [7:0] a, logic [7:0] e);
    @(negedge clk); addr = a;
    @(negedge clk); chk("rdata", rd_q, e);
  endtask : rd_reg
  // Span from first to last step, so the free-running timer phase drops out
  task step_run(logic [7:0] cfg, logic [4:0] t, int span);
    int k, t1;
    k = 0; t1 = 0; n = 0;
    wr_reg(8'h24, cfg); tgt = t;
    while (n < 2000 && code !== t) begin
      @(negedge clk); n++;
      if (stp === 1'b1) begin
        k++;
        if (k == 1) t1 = n;
      end
    end
    chk("step count", 16'(k), 16'h0003);
    chk("step span", 16'(n - t1), 16'(span));
    $display("test step rate %h done", cfg);
  endtask : step_run
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    #200000; bad_count++; close_out;
  end
  initial begin
    repeat (20) @(negedge clk); rst_b = 1;
    rd_reg(8'h24, 8'h4d);
    rd_reg(8'h32, 8'h4d);
    rd_reg(8'h35, 8'h3f);
    chk("fields", {volt, ph, fq, ilim, hi}, 16'h07cf);
    $display("test reset defaults done");
    wr_reg(8'h24, 8'hff); rd_reg(8'h24, 8'h7d);
    chk("config fields", {ph, fq, ilim}, 16'h001f);
    wr_reg(8'h32, 8'h00); rd_reg(8'h24, 8'h00);
    wr_reg(8'h35, 8'hff); rd_reg(8'h35, 8'h3f);
    wr_reg(8'h35, 8'h0a); chk("voltage fields", {hi, volt}, 16'h000a);
    wr_reg(8'h33, 8'hff); rd_reg(8'h33, 8'h00); rd_reg(8'h35, 8'h0a);
    $display("test register access done");
    step_run(8'h00, 5'h03, 400);
    step_run(8'h40, 5'h00, 800);
    close_out;
  end
endmodule : tb_bcr_regs
